// File: rtl/sprf_frame.v
/*
  SPI responder frame logic (mode 0): shifts frames in and out, checks CRC,
  keeps incoming and outgoing buffers and flags stale/error/no-clock frames.
  Assumes the SPI pins are asynchronous to ref_clk and that ref_clk is at
  least 8x the serial clock, so every serial edge is seen after sync.
*/
// How it works
// - chip select low with static serial clock for two seconds resets link.
// - first byte is direction bit then 7-bit address, msb first.
// - write carries data in byte two; read ignores it except for CRC.
// - good CRC moves direction, address and data into incoming buffer.
// - bad CRC drops frame, next frame returns FFFF then AA.
// - each frame shifts out the outgoing buffer while receiving.
// - buffer not refreshed since last frame returns FFFF then 00.
// - processed write is echoed into the outgoing buffer.
// - read answer places direction, address and data in outgoing buffer.
// - CRC over two outgoing bytes goes out third, except fixed patterns.
// - write of AA to address 7F is a separate special action.
// - clock idles low, data sampled on rising, changed on falling.
// - frames are 16 clocks, or 24 with CRC on; other counts up to 30 flag an error.
// - CRC polynomial x^8+x^2+x+1, initial value zero.
// - oscillator not running at frame start gives all ones out.
`timescale 1ns/1ps
`include "sprf_defs.vh"

module sprf_frame #(
  parameter FREEZE_CYCLES = `SPRF_FREEZE_CYCLES
) (
  input wire ref_clk,
  input wire reset_n,
  input wire crc_enable,
  input wire osc_running,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  output reg in_valid,
  output reg in_dir,
  output reg [6:0] in_addr,
  output reg [7:0] in_data,
  output reg special_action,
  output reg frame_error,
  output reg link_reset,
  input wire out_load,
  input wire out_dir,
  input wire [6:0] out_addr,
  input wire [7:0] out_data
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] sclk_sync;
  reg [1:0] cs_sync;
  reg [1:0] mosi_sync;
  reg sclk_prev;
  reg cs_prev;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_sync <= 2'b00;
      cs_sync <= 2'b11;
      mosi_sync <= 2'b00;
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else begin
      sclk_sync <= {sclk_sync[0], spi_sclk};
      cs_sync <= {cs_sync[0], spi_cs_n};
      mosi_sync <= {mosi_sync[0], spi_mosi};
      sclk_prev <= sclk_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  wire sclk_s = sclk_sync[1];
  wire cs_s = cs_sync[1];
  wire sclk_rise = sclk_s & ~sclk_prev;
  wire sclk_fall = ~sclk_s & sclk_prev;
  wire frame_start = ~cs_s & cs_prev;
  wire frame_end = cs_s & ~cs_prev;

  // ----------------------------------------------------------------
  // crc step, one bit at a time
  // ----------------------------------------------------------------
  function [7:0] crc_bit;
    input [7:0] crc;
    input din;
    begin
      crc_bit = {crc[6:0], 1'b0} ^ ((crc[7] ^ din) ? `SPRF_CRC_POLY : 8'h00);
    end
  endfunction

  function [7:0] crc_word;
    input [15:0] word;
    integer i;
    reg [7:0] c;
    begin
      c = `SPRF_CRC_INIT;
      for (i = 15; i >= 0; i = i - 1) begin
        c = crc_bit(c, word[i]);
      end
      crc_word = c;
    end
  endfunction

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  reg [4:0] bit_count;
  reg [15:0] rx_word;
  reg [7:0] rx_crc;
  reg [7:0] calc_crc;
  reg [23:0] tx_shift;
  reg [15:0] out_word;
  reg [7:0] out_crc;
  reg out_fresh;
  reg nack_pending;
  reg [31:0] idle_count;

  wire [4:0] expect_bits = crc_enable ? `SPRF_BITS_CRC : `SPRF_BITS_PLAIN;
  wire count_ok = (bit_count == expect_bits);
  wire crc_ok = ~crc_enable | (calc_crc == rx_crc);
  wire freeze = (idle_count >= FREEZE_CYCLES - 1);

  // what goes out this frame; fixed patterns win over fresh content
  reg [23:0] next_tx;
  always @* begin
    if (!osc_running) begin
      next_tx = {`SPRF_STALE_WORD, `SPRF_CRC_NOCLK};
    end else if (nack_pending) begin
      next_tx = {`SPRF_STALE_WORD, `SPRF_CRC_BAD};
    end else if (!out_fresh) begin
      next_tx = {`SPRF_STALE_WORD, `SPRF_CRC_STALE};
    end else begin
      next_tx = {out_word, out_crc};
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_count <= 5'h00;
      rx_word <= 16'h0000;
      rx_crc <= 8'h00;
      calc_crc <= `SPRF_CRC_INIT;
      tx_shift <= 24'hFF_FFFF;
      out_word <= `SPRF_STALE_WORD;
      out_crc <= `SPRF_CRC_STALE;
      out_fresh <= 1'b0;
      nack_pending <= 1'b0;
      idle_count <= 32'h0000_0000;
      spi_miso <= 1'b1;
      spi_miso_oe <= 1'b0;
      in_valid <= 1'b0;
      in_dir <= 1'b0;
      in_addr <= 7'h00;
      in_data <= 8'h00;
      special_action <= 1'b0;
      frame_error <= 1'b0;
      link_reset <= 1'b0;
    end else begin
      in_valid <= 1'b0;
      special_action <= 1'b0;
      frame_error <= 1'b0;
      link_reset <= 1'b0;
      // internal logic refresh; load takes the echo or the read answer
      if (out_load) begin
        out_word <= {out_dir, out_addr, out_data};
        out_crc <= crc_word({out_dir, out_addr, out_data});
        out_fresh <= 1'b1;
      end
      if (cs_s || sclk_rise || sclk_fall) begin
        idle_count <= 32'h0000_0000;
      end else if (!freeze) begin
        idle_count <= idle_count + 32'h0000_0001;
      end
      if (frame_start) begin
        bit_count <= 5'h00;
        calc_crc <= `SPRF_CRC_INIT;
        tx_shift <= {next_tx[22:0], 1'b1};
        spi_miso <= next_tx[23]; // first bit valid before first rise
        spi_miso_oe <= 1'b1;
      end else if (!cs_s && freeze) begin
        // frozen bus: drop the frame and wait for chip select to rise
        link_reset <= ~spi_miso_oe ? 1'b0 : 1'b1;
        spi_miso_oe <= 1'b0;
        spi_miso <= 1'b1;
        bit_count <= 5'h1F;
      end else if (!cs_s && spi_miso_oe) begin
        if (sclk_rise) begin
          if (bit_count != 5'h1F) begin
            bit_count <= bit_count + 5'h01;
          end
          if (bit_count < `SPRF_BITS_PLAIN) begin
            rx_word <= {rx_word[14:0], mosi_sync[1]};
            calc_crc <= crc_bit(calc_crc, mosi_sync[1]);
          end else begin
            rx_crc <= {rx_crc[6:0], mosi_sync[1]};
          end
        end
        if (sclk_fall) begin
          spi_miso <= tx_shift[23];
          tx_shift <= {tx_shift[22:0], 1'b1};
        end
      end
      if (frame_end) begin
        spi_miso_oe <= 1'b0;
        spi_miso <= 1'b1;
        if (out_load) begin
          out_fresh <= 1'b1;
        end else begin
          out_fresh <= 1'b0;
        end
        nack_pending <= 1'b0;
        if (bit_count == 5'h1F || !osc_running) begin
          // frame lost to freeze or no clock: nothing taken
        end else if (!count_ok) begin
          frame_error <= 1'b1;
        end else if (!crc_ok) begin
          nack_pending <= 1'b1;
        end else begin
          in_valid <= 1'b1;
          in_dir <= rx_word[15];
          in_addr <= rx_word[14:8];
          in_data <= rx_word[7:0];
          if (rx_word[15] == `SPRF_DIR_WRITE &&
              rx_word[14:8] == `SPRF_SPECIAL_ADDR &&
              rx_word[7:0] == `SPRF_SPECIAL_DATA) begin
            special_action <= 1'b1;
          end
        end
      end
    end
  end

endmodule // sprf_frame

// File: rtl/sprf_defs.vh
/*
  Constants for the SPI responder frame logic: frame sizes, flag patterns,
  CRC polynomial and the bus-freeze timeout.
  Assumes a 50 MHz ref_clk; included by rtl/sprf_frame.v.
*/
`ifndef SPRF_DEFS_VH
`define SPRF_DEFS_VH

`define SPRF_CLK_HZ 50000000
`define SPRF_FREEZE_MS 2000
`define SPRF_FREEZE_CYCLES (`SPRF_CLK_HZ / 1000 * `SPRF_FREEZE_MS)
`define SPRF_BITS_PLAIN 5'h10
`define SPRF_BITS_CRC 5'h18
`define SPRF_STALE_WORD 16'hFFFF
`define SPRF_CRC_BAD 8'hAA
`define SPRF_CRC_STALE 8'h00
`define SPRF_CRC_NOCLK 8'hFF
`define SPRF_CRC_POLY 8'h07
`define SPRF_CRC_INIT 8'h00
`define SPRF_SPECIAL_ADDR 7'h7F
`define SPRF_SPECIAL_DATA 8'hAA
`define SPRF_DIR_WRITE 1'b1

`endif

// File: testbench/sprf_frame_props.sv
/*
  Port checker for sprf_frame.
  Assumes it is bound to the design; sees only the design's ports.
*/
`timescale 1ns/1ps
module sprf_frame_props (
  input wire ref_clk,
  input wire reset_n,
  input wire spi_cs_n,
  input wire spi_miso,
  input wire spi_miso_oe,
  input wire in_valid,
  input wire in_dir,
  input wire [6:0] in_addr,
  input wire [7:0] in_data,
  input wire special_action,
  input wire frame_error,
  input wire link_reset
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence frame_start;
    $fell(spi_cs_n);
  endsequence
  sequence frame_end;
    $rose(spi_cs_n) ##1 spi_cs_n[*7];
  endsequence
  AST_OE_ON: assert property (frame_start |-> ##[1:6] spi_miso_oe)
    else $error("miso not driven after select");
  AST_OE_OFF: assert property (frame_end |-> !spi_miso_oe)
    else $error("miso still driven after deselect");
  AST_IDLE_ONE: assert property (!spi_miso_oe |-> spi_miso)
    else $error("idle miso not high");
  AST_VALID_PULSE: assert property (in_valid |=> !in_valid)
    else $error("valid longer than one cycle");
  AST_VALID_END: assert property (in_valid |-> spi_cs_n && !frame_error)
    else $error("valid outside frame end");
  AST_HOLD: assert property (!in_valid |-> $stable({in_dir, in_addr, in_data}))
    else $error("incoming word changed without valid");
  AST_SPECIAL: assert property (special_action |-> in_valid && in_dir &&
    in_addr == 7'h7F && in_data == 8'hAA)
    else $error("special action on wrong frame");
  AST_SPECIAL_NEED: assert property (in_valid && in_dir &&
    {in_addr, in_data} == 15'h7FAA |-> special_action)
    else $error("special frame without action");
  AST_ERR_END: assert property (frame_error |-> spi_cs_n)
    else $error("count error inside frame");
  AST_LINK: assert property (link_reset |-> ##[0:1] !spi_miso_oe)
    else $error("link not released after freeze");
endmodule // sprf_frame_props

// File: testbench/sprf_host.sv
/*
  SPI controller model, mode 0, msb first.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/1ps
module sprf_host (
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // ----
  // link
  // ----
  initial begin
    spi_sclk = 0;
    spi_cs_n = 1;
    spi_mosi = 0;
  end
  // the 7 ns offset keeps serial edges off the sampling clock's edges
  task automatic xfer(input int n, input logic [23:0] tx,
    output logic [23:0] rx);
    rx = 0;
    #7 spi_cs_n = 0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_mosi = tx[i];
      #80 spi_sclk = 1;
      rx = {rx[22:0], spi_miso};
      #80 spi_sclk = 0;
    end
    #80 spi_cs_n = 1;
    spi_mosi = ~spi_mosi;
    #200;
  endtask
  task automatic freeze(input int t);
    #7 spi_cs_n = 0;
    #t spi_cs_n = 1;
    #200;
  endtask
endmodule // sprf_host

// File: testbench/sprf_frame_test.sv
/*
  Self-checking bench for sprf_frame with a host model.
  Assumes a shortened freeze timeout of 200 cycles.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module sprf_frame_test;
  logic ref_clk = 0, reset_n = 0, crc_enable = 1, osc_running = 1;
  logic out_load = 0, out_dir = 0;
  logic [6:0] out_addr = 0;
  logic [7:0] out_data = 0;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  wire in_valid, in_dir, special_action, frame_error, link_reset;
  wire [6:0] in_addr;
  wire [7:0] in_data;
  int failures = 0, checks = 0, nv = 0, ns = 0, ne = 0, nl = 0, v;
  logic [31:0] r = 6;
  logic [23:0] rx, g;
  logic [15:0] w, t;
  sprf_frame #(.FREEZE_CYCLES(200)) u_dut (.*);
  sprf_host u_host (.*);
  // ----
  // helpers
  // ----
  initial forever #10 ref_clk = ~ref_clk;
  // counted off the launching edge so the pulses are settled
  always @(negedge ref_clk) begin
    nv += in_valid;
    ns += special_action;
    ne += frame_error;
    nl += link_reset;
  end
  function automatic logic [15:0] xs();
    r ^= r << 13;
    r ^= r >> 17;
    r ^= r << 5;
    return r[15:0];
  endfunction
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic load(input logic [15:0] d, input logic c);
    @(negedge ref_clk);
    crc_enable = c;
    {out_dir, out_addr, out_data} = d;
    out_load = 1;
    @(negedge ref_clk);
    out_load = 0;
  endtask
  // internal logic that answers only after d cycles of work
  task automatic slow_load(input int d, input logic [15:0] x);
    repeat (d) @(negedge ref_clk);
    {out_dir, out_addr, out_data} = x;
    out_load = 1;
    @(negedge ref_clk);
    out_load = 0;
  endtask
  task automatic frame(input int n, input logic [23:0] tx);
    @(negedge ref_clk);
    u_host.xfer(n, tx, rx);
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // about 20 frames of at most about 4.2 us each; 1 ms is ample
  initial begin
    #1ms;
    failures++;
    wrap_up();
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (8) @(negedge ref_clk);
    reset_n = 1;
    g = {16'h0155, crc8(16'h0155)};
    frame(24, g);
    `CHK("stale", 24'hFFFF00, rx)
    for (int k = 0; k < 6; k++) begin
      v = nv;
      w = xs();
      t = xs();
      load(w, k[0]);
      frame(k[0] ? 24 : 16, k[0] ? {t, crc8(t)} : {8'h00, t});
      `CHK("echo", k[0] ? {w, crc8(w)} : {8'h00, w}, rx)
      `CHK("taken", {v + 1, t}, {nv, in_dir, in_addr, in_data})
    end
    $display("test echo done");
    v = nv;
    frame(24, {16'h0155, ~crc8(16'h0155)});
    `CHK("drop", v, nv)
    load(16'h0203, 1);
    frame(24, g);
    `CHK("crcbad", 24'hFF_FFAA, rx)
    `CHK("resend", v + 1, nv)
    frame(24, g);
    `CHK("consumed", 24'hFF_FF00, rx)
    load(16'h0203, 1);
    frame(24, g);
    `CHK("retry", {16'h0203, crc8(16'h0203)}, rx)
    $display("test crc done");
    @(negedge ref_clk);
    osc_running = 0;
    v = nv;
    load(16'h0203, 1);
    frame(24, g);
    `CHK("noclk", 24'hFF_FFFF, rx)
    @(negedge ref_clk);
    osc_running = 1;
    frame(24, g);
    `CHK("retried", v + 1, nv)
    v = ne;
    load(16'h0203, 0);
    frame(17, g);
    `CHK("count", v + 1, ne)
    v = ns;
    load(16'h0203, 1);
    frame(24, {16'hFFAA, crc8(16'hFFAA)});
    `CHK("special", v + 1, ns)
    // scaled waits: an early read sees stale, a patient one the answer
    fork
      slow_load(400, 16'h4012);
      begin
        frame(24, g);
        `CHK("early", 24'hFF_FF00, rx)
        repeat (400) @(negedge ref_clk);
        frame(24, g);
        `CHK("late", {16'h4012, crc8(16'h4012)}, rx)
      end
    join
    fork
      slow_load(1200, 16'h0004);
      begin
        repeat (400) @(negedge ref_clk);
        frame(24, g);
        `CHK("sig_early", 24'hFF_FF00, rx)
        repeat (1000) @(negedge ref_clk);
        frame(24, g);
        `CHK("sig_late", {16'h0004, crc8(16'h0004)}, rx)
      end
    join
    v = nl;
    u_host.freeze(6000);
    `CHK("freeze", v + 1, nl)
    $display("test faults done");
    wrap_up();
  end
endmodule // sprf_frame_test
bind sprf_frame sprf_frame_props u_props (.*);
